// File: rtl/phbg_line_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pixel counter restarted at every zero crossing
module phbg_line_counter (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        restart,
	output logic      [11:0] count
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 12'h000;
		end else if (restart) begin
			count <= 12'h001;
		end else if (count != 12'hfff) begin
			// saturate so a lost flyback never wraps into a false start
			count <= count + 12'h001;
		end
	end
endmodule
`default_nettype wire

// File: rtl/phbg_map.svh
`ifndef PHBG_MAP_SVH
`define PHBG_MAP_SVH
// ==========================================================
// register map
`define PHBG_CTRL_ADDR      16'h843a
`define PHBG_CTRL_RESET     8'h01
`define PHBG_BIT_HBLANK_EN  0
`define PHBG_BIT_PROG_EN    2
`define PHBG_STEP_LSB       3
`define PHBG_STEP_MSB       6
// ==========================================================
// timing
`define PHBG_STEP_PIXELS    4
`define PHBG_MAX_STEPS      16
`define PHBG_PPL_BASE       704
`define PHBG_PPL_INCR       64
`define PHBG_DEFAULT_DELAY  4
`endif

// File: rtl/phbg_pkg.sv
`default_nettype none
package phbg_pkg;
	typedef struct packed {
		logic [3:0] steps;
		logic       prog_en;
		logic       hblank_en;
	} phbg_ctrl_t;

	typedef enum logic [1:0] {
		PHBG_IDLE,
		PHBG_ADVANCE,
		PHBG_FLYBACK,
		PHBG_DELAY
	} phbg_state_t;
endpackage
`default_nettype wire

// File: rtl/phbg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "phbg_map.svh"
module phbg_top (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        retrace_pulse_current,
	input  wire logic [2:0]  pixels_per_line_setting,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             hblank
);
	// ==========================================================
	// control register
	logic [7:0]             ctrl_q;
	phbg_pkg::phbg_ctrl_t   ctrl;
	logic                   sel;

	assign sel = (reg_addr == `PHBG_CTRL_ADDR);
	assign ctrl = '{
		steps:     ctrl_q[`PHBG_STEP_MSB:`PHBG_STEP_LSB],
		prog_en:   ctrl_q[`PHBG_BIT_PROG_EN],
		hblank_en: ctrl_q[`PHBG_BIT_HBLANK_EN]
	};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= `PHBG_CTRL_RESET;
		end else if (reg_wr && sel) begin
			ctrl_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= sel ? ctrl_q : 8'h00;
		end
	end

	// ==========================================================
	// flyback edges
	logic flyback_q;
	logic fb_rise;
	logic fb_fall;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flyback_q <= 1'b0;
		end else begin
			flyback_q <= retrace_pulse_current;
		end
	end
	assign fb_rise = retrace_pulse_current && !flyback_q;
	assign fb_fall = !retrace_pulse_current && flyback_q;

	// ==========================================================
	// line length and advance point
	logic [11:0] count;
	logic [11:0] line_len;
	logic [11:0] advance;
	logic [11:0] start_at;
	logic        adv_on;

	phbg_line_counter u_cnt (
		.clk     (clk),
		.rst_b   (rst_b),
		.restart (fb_rise),
		.count   (count)
	);

	// line length: base plus 64 per setting step
	assign line_len = 12'(`PHBG_PPL_BASE)
		+ 12'(pixels_per_line_setting) * 12'(`PHBG_PPL_INCR);
	// field 0 means one step; 16 steps fill the 4-bit field
	assign advance = (12'(ctrl.steps) + 12'h001)
		* 12'(`PHBG_STEP_PIXELS);
	assign start_at = line_len - advance;
	assign adv_on = ctrl.hblank_en && ctrl.prog_en;

	// ==========================================================
	// blanking sequencer
	phbg_pkg::phbg_state_t state_q;
	logic [3:0]            dly_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= phbg_pkg::PHBG_IDLE;
			dly_q   <= 4'h0;
		end else if (!ctrl.hblank_en) begin
			state_q <= phbg_pkg::PHBG_IDLE;
			dly_q   <= 4'h0;
		end else begin
			case (state_q)
			phbg_pkg::PHBG_IDLE: begin
				if (adv_on && count == start_at) begin
					state_q <= phbg_pkg::PHBG_ADVANCE;
				end else if (fb_rise && adv_on) begin
					state_q <= phbg_pkg::PHBG_FLYBACK;
				end else if (fb_rise) begin
					state_q <= phbg_pkg::PHBG_DELAY;
					dly_q   <= 4'(`PHBG_DEFAULT_DELAY);
				end
			end
			phbg_pkg::PHBG_ADVANCE: begin
				// start never moves after the crossing
				if (fb_rise) begin
					state_q <= phbg_pkg::PHBG_FLYBACK;
				end else if (!adv_on) begin
					// advance dropped mid-line: wait for the crossing
					state_q <= phbg_pkg::PHBG_IDLE;
				end
			end
			phbg_pkg::PHBG_DELAY: begin
				if (fb_fall) begin
					state_q <= phbg_pkg::PHBG_IDLE;
				end else if (dly_q == 4'h1) begin
					state_q <= phbg_pkg::PHBG_FLYBACK;
				end else begin
					dly_q <= dly_q - 4'h1;
				end
			end
			phbg_pkg::PHBG_FLYBACK: begin
				if (fb_fall) begin
					state_q <= phbg_pkg::PHBG_IDLE;
				end
			end
			default: state_q <= phbg_pkg::PHBG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hblank <= 1'b0;
		end else begin
			hblank <= ctrl.hblank_en &&
				(state_q == phbg_pkg::PHBG_ADVANCE ||
				 state_q == phbg_pkg::PHBG_FLYBACK);
		end
	end

	// ==========================================================
	// checks
	property p_reset_en;
		@(posedge clk) $rose(rst_b) |-> ctrl.hblank_en;
	endproperty
	a_reset_en: assert property (p_reset_en)
		else $error("blank enable not set after reset");

	property p_adv_start;
		@(posedge clk) disable iff (!rst_b)
		(state_q == phbg_pkg::PHBG_IDLE && adv_on && count == start_at
		 && !reg_wr) |-> ##2 hblank;
	endproperty
	a_adv_start: assert property (p_adv_start)
		else $error("advanced blank did not start");

	property p_need_both;
		@(posedge clk) disable iff (!rst_b)
		!adv_on |=> state_q != phbg_pkg::PHBG_ADVANCE;
	endproperty
	a_need_both: assert property (p_need_both)
		else $error("advance active without both enables");

	property p_end_fall;
		@(posedge clk) disable iff (!rst_b)
		(fb_fall && state_q == phbg_pkg::PHBG_FLYBACK) |-> ##2 !hblank;
	endproperty
	a_end_fall: assert property (p_end_fall)
		else $error("blank did not end with flyback");

	property p_disabled;
		@(posedge clk) disable iff (!rst_b)
		!ctrl.hblank_en |=> !hblank;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("blank while disabled");

	property p_step_field;
		@(posedge clk) disable iff (!rst_b)
		(reg_wr && sel) |=> ctrl.steps == $past(reg_wdata[6:3]);
	endproperty
	a_step_field: assert property (p_step_field)
		else $error("step field not taken from bits 6:3");

	property p_adv_range;
		@(posedge clk) disable iff (!rst_b)
		advance >= 12'h004 && advance <= 12'h040;
	endproperty
	a_adv_range: assert property (p_adv_range)
		else $error("advance out of range");

	property p_default_delay;
		@(posedge clk) disable iff (!rst_b)
		(state_q == phbg_pkg::PHBG_IDLE && fb_rise && !adv_on
		 && ctrl.hblank_en && !reg_wr && count != start_at)
		|=> state_q == phbg_pkg::PHBG_DELAY;
	endproperty
	a_default_delay: assert property (p_default_delay)
		else $error("fixed delay not used");

	c_adv: cover property (@(posedge clk)
		state_q == phbg_pkg::PHBG_ADVANCE ##[1:200] fb_rise);
	c_dly: cover property (@(posedge clk)
		state_q == phbg_pkg::PHBG_DELAY ##[1:8]
		state_q == phbg_pkg::PHBG_FLYBACK);
	c_end: cover property (@(posedge clk) $fell(hblank));
	c_max: cover property (@(posedge clk)
		state_q == phbg_pkg::PHBG_ADVANCE && ctrl.steps == 4'hf);
endmodule
`default_nettype wire

// File: verification/phbg_flyback_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// flyback source, free running, one pulse per line
module phbg_flyback_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] line_sel,
	output logic            pulse
);
	logic [11:0] cnt_q;
	wire  [11:0] line_len;
	assign line_len = 12'h2c0 + 12'h040 * {9'h000, line_sel};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cnt_q <= 12'h000;
		else if (cnt_q >= line_len - 12'h001)
			cnt_q <= 12'h000;
		else
			cnt_q <= cnt_q + 12'h001;
	end
	// 40 pixel flyback at line start
	assign pulse = rst_b && (cnt_q < 12'h028);
endmodule
`default_nettype wire

// File: verification/tb_programmable_hblank_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_programmable_hblank_generator;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        fly;
	logic [2:0]  line_sel = 3'h0;
	logic        wr_en = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        hblank;
	int          fail_count = 0;
	int          tests_run = 0;
	int          lead;
	int          tail;
	int          rise;
	int          lead0;
	always #5 clk = ~clk;
	phbg_top i_dut (.clk(clk), .rst_b(rst_b), .retrace_pulse_current(fly),
		.pixels_per_line_setting(line_sel), .reg_wr(wr_en), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .hblank(hblank));
	phbg_flyback_model i_fly (.clk(clk), .rst_b(rst_b),
		.line_sel(line_sel), .pulse(fly));
	// ==========================================================
	// helpers
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		step();
		wr_en = 1'b0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] exp);
		addr = a;
		step();
		step();
		check("rdata", rdata, exp);
	endtask
	// edges counted from a flyback fall; bounded by two lines
	task automatic measure();
		int  c;
		int  fr;
		int  ff;
		int  hf;
		logic pf;
		logic ph;
		logic stuck;
		fr = -1;
		ff = -1;
		hf = -1;
		rise = -1;
		for (c = 0; c < 2400 && fly !== 1'b1; c++)
			step();
		for (c = 0; c < 2400 && fly !== 1'b0; c++)
			step();
		stuck = (fly !== 1'b0);
		for (c = 0; c < 2400 && hf < 0; c++) begin
			pf = fly;
			ph = hblank;
			step();
			if (ph === 1'b0 && hblank === 1'b1 && rise < 0)
				rise = c;
			if (pf === 1'b0 && fly === 1'b1)
				fr = c;
			if (pf === 1'b1 && fly === 1'b0 && fr >= 0)
				ff = c;
			if (ph === 1'b1 && hblank === 1'b0 && ff >= 0)
				hf = c;
		end
		if (stuck || fr < 0) begin
			fail_count++;
			finish_test();
		end else begin
			lead = fr - rise;
			tail = hf - ff;
		end
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd(16'h843a, 8'h01);
		rd(16'h843b, 8'h00);
		wr(16'h843a, 8'h7d);
		rd(16'h843a, 8'h7d);
		wr(16'h0000, 8'hff);
		rd(16'h843a, 8'h7d);
	endtask
	task automatic t_advance();
		wr(16'h843a, 8'h05);
		measure();
		measure();
		lead0 = lead;
		check("lead_pos", lead > 0, 1);
		check("tail", tail, 2);
		wr(16'h843a, 8'h7d);
		measure();
		measure();
		check("adv16", lead - lead0, 60);
		check("tail", tail, 2);
		line_sel = 3'h7;
		measure();
		measure();
		check("adv_ppl", lead - lead0, 60);
		line_sel = 3'h0;
	endtask
	task automatic t_modes();
		wr(16'h843a, 8'h79);
		measure();
		measure();
		check("fixed", lead < 0 && lead >= -8, 1);
		check("tail", tail, 2);
		wr(16'h843a, 8'h7c);
		measure();
		measure();
		check("off", rise, -1);
		check("off_lvl", hblank, 0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst_b = 1'b1;
		t_regs();
		t_advance();
		t_modes();
		finish_test();
	end
endmodule
`default_nettype wire
